// ### sbs_map.svh
// Register indices, field positions, reset values and timing counts of the servo brake sequencer.
// Notes on behaviour
// - An overflow alarm is raised whenever the deviation counter exceeds the programmed threshold, which is settable in single pulses from 1 to 83886080;
//   the threshold register takes any 32-bit value, 0 included, with no limit.
// - The overflow threshold resets to 41943040 pulses and a written value takes effect at once.
// - The four brake timing settings act only while the brake control output function is enabled.
// - With a positive servo-on wait, servo-on asserts the brake control output first and excites the motor after that many milliseconds.
// - With a negative servo-on wait, servo-on excites the motor at once and asserts the brake control output after the magnitude in milliseconds.
// - With the motor stopped, servo-off deasserts the brake control output at once.
// - Motor power is removed the servo-off wait times 10 ms after servo-off, and the default of 0 means no delay.
// - After servo-off the brake action happens once the motor speed falls below the brake speed threshold, default 100 rpm.
// - After servo-off the brake action happens once the elapsed time exceeds the brake wait times 10 ms, default 50.
// - The post-servo-off brake action happens on whichever of the speed and time conditions is met first.
// - All five settings take effect as soon as they are written, with no restart.
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_IDX_DEV_THR       14'h335c
`define SBS_IDX_ON_WAIT       14'h335d
`define SBS_IDX_OFF_WAIT      14'h335e
`define SBS_IDX_BRK_SPEED     14'h335f
`define SBS_IDX_BRK_WAIT      14'h3360
`define SBS_IDX_CTRL          14'h3370
`define SBS_IDX_STATUS        14'h3371
`define SBS_IDX_IRQ_STAT      14'h3372
`define SBS_IDX_IRQ_MASK      14'h3373

`define SBS_RST_DEV_THR       32'h02800000
`define SBS_RST_ON_WAIT       16'h0000
`define SBS_RST_OFF_WAIT      16'h0000
`define SBS_RST_BRK_SPEED     16'h0064
`define SBS_RST_BRK_WAIT      16'h0032
`define SBS_RST_CTRL          32'h00000001
`define SBS_RST_IRQ_MASK      32'h00000000

`define SBS_CTRL_BRK_EN       0
`define SBS_ST_BRAKE          0
`define SBS_ST_EXCITE         1
`define SBS_ST_ALARM          2
`define SBS_ST_STATE_LO       4
`define SBS_IRQ_ALARM         0
`define SBS_IRQ_BRAKE_OFF     1
`define SBS_IRQ_EXCITE_ON     2
`define SBS_IRQ_EXCITE_OFF    3
`define SBS_IRQ_BITS          4

`define SBS_CLK_NS            50
`define SBS_TICK_NS           1000000
`define SBS_UNIT_MS           10
`define SBS_MS_MAX            13'h1fff

`endif

// ### sbs_pkg.sv
// Types shared by the servo brake sequencer modules.
package sbs_pkg;

	typedef enum logic [1:0] {
		SBS_OFF,
		SBS_ON_SEQ,
		SBS_ON,
		SBS_OFF_SEQ
	} sbs_state_e;

	typedef struct packed {
		logic [31:0] devThr;
		logic [15:0] onWait;
		logic [15:0] offWait;
		logic [15:0] brkSpeed;
		logic [15:0] brkWait;
		logic        brkEn;
	} sbs_cfg_s;

	typedef struct packed {
		logic brake;
		logic excite;
		logic alarm;
	} sbs_out_s;

endpackage : sbs_pkg

// ### sbs_ms_tick.sv
// Millisecond tick divider with a restart input.
module sbs_ms_tick #(
	parameter int CYCLES = 20000
) (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic restart,
	output logic      tick
);

	logic [14:0] divCnt_reg;
	wire         atEnd = (divCnt_reg == 15'(CYCLES - 1));

	// Restarting the divider makes every wait start on a full millisecond.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divCnt_reg <= 15'h0000;
		end else if (restart || atEnd) begin
			divCnt_reg <= 15'h0000;
		end else begin
			divCnt_reg <= divCnt_reg + 15'h0001;
		end
	end

	assign tick = atEnd && !restart;

endmodule : sbs_ms_tick

// ### sbs_dev_cmp.sv
// Deviation magnitude comparator that raises the overflow alarm.
module sbs_dev_cmp (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [31:0] deviation,
	input  wire logic [31:0] threshold,
	output logic             alarm
);

	// One extra bit keeps the magnitude of the most negative count exact.
	wire [32:0] devMag = deviation[31] ? (33'h000000000 - {deviation[31], deviation})
	                                   : {1'b0, deviation};
	wire        over   = devMag > {1'b0, threshold};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alarm <= 1'b0;
		end else begin
			alarm <= over;
		end
	end

endmodule : sbs_dev_cmp

// ### sbs_top.sv
// Servo brake sequencer top: APB registers, brake and excitation sequencing, interrupts.
`include "sbs_map.svh"

module sbs_top
	import sbs_pkg::*;
#(
	parameter int MS_CYCLES = `SBS_TICK_NS / `SBS_CLK_NS
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        servoCmd,
	input  wire logic [15:0] motorSpeed,
	input  wire logic [31:0] deviation,
	output logic             brakeCtrlOut,
	output logic             motorExcite,
	output logic             devAlarm,
	output logic             irq
);

	sbs_cfg_s   cfg_reg;
	sbs_out_s   out_reg;
	sbs_out_s   out_next;
	sbs_state_e state_reg;
	sbs_state_e state_next;
	logic [`SBS_IRQ_BITS-1:0] irqStat_reg;
	logic [`SBS_IRQ_BITS-1:0] irqStat_next;
	logic [`SBS_IRQ_BITS-1:0] irqMask_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        servoPrev_reg;
	logic [12:0] msCnt_reg;
	logic        msTick;
	logic        alarm;

	// Bus decode.
	wire [13:0] regIdx   = paddr[15:2];
	wire        aligned  = (paddr[1:0] == 2'h0);
	wire        hitThr   = aligned && (regIdx == `SBS_IDX_DEV_THR);
	wire        hitOnW   = aligned && (regIdx == `SBS_IDX_ON_WAIT);
	wire        hitOffW  = aligned && (regIdx == `SBS_IDX_OFF_WAIT);
	wire        hitSpd   = aligned && (regIdx == `SBS_IDX_BRK_SPEED);
	wire        hitBrkW  = aligned && (regIdx == `SBS_IDX_BRK_WAIT);
	wire        hitCtrl  = aligned && (regIdx == `SBS_IDX_CTRL);
	wire        hitStat  = aligned && (regIdx == `SBS_IDX_STATUS);
	wire        hitIrqS  = aligned && (regIdx == `SBS_IDX_IRQ_STAT);
	wire        hitIrqM  = aligned && (regIdx == `SBS_IDX_IRQ_MASK);
	wire        hitAny   = hitThr | hitOnW | hitOffW | hitSpd | hitBrkW
	                     | hitCtrl | hitStat | hitIrqS | hitIrqM;
	wire        access   = psel && penable;
	wire        wrEn     = access && pwrite && hitAny;
	wire        rdEn     = access && !pwrite && hitAny;
	wire        rdLoad   = psel && !penable && !pwrite && hitAny;
	wire        wrThr    = wrEn && hitThr;
	wire        wrOnW    = wrEn && hitOnW;
	wire        wrOffW   = wrEn && hitOffW;
	wire        wrSpd    = wrEn && hitSpd;
	wire        wrBrkW   = wrEn && hitBrkW;
	wire        wrCtrl   = wrEn && hitCtrl;
	wire        wrIrqM   = wrEn && hitIrqM;
	wire        irqRdClr = rdEn && hitIrqS;

	assign pready  = 1'b1;
	assign pslverr = access && !hitAny;
	assign prdata  = prdata_reg;

	wire [31:0] statusWord = {26'h0000000, state_reg, 1'b0,
	                          out_reg.alarm, out_reg.excite, out_reg.brake};

	assign prdata_next = hitThr  ? cfg_reg.devThr :
	                     hitOnW  ? {16'h0000, cfg_reg.onWait} :
	                     hitOffW ? {16'h0000, cfg_reg.offWait} :
	                     hitSpd  ? {16'h0000, cfg_reg.brkSpeed} :
	                     hitBrkW ? {16'h0000, cfg_reg.brkWait} :
	                     hitCtrl ? {31'h00000000, cfg_reg.brkEn} :
	                     hitStat ? statusWord :
	                     hitIrqS ? {28'h0000000, irqStat_reg} :
	                     hitIrqM ? {28'h0000000, irqMask_reg} :
	                               32'h00000000;

	// Settings are read live by the sequencer, so a write acts on the next cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.devThr <= `SBS_RST_DEV_THR;
		end else if (wrThr) begin
			cfg_reg.devThr <= pwdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.onWait <= `SBS_RST_ON_WAIT;
		end else if (wrOnW) begin
			cfg_reg.onWait <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.offWait <= `SBS_RST_OFF_WAIT;
		end else if (wrOffW) begin
			cfg_reg.offWait <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.brkSpeed <= `SBS_RST_BRK_SPEED;
		end else if (wrSpd) begin
			cfg_reg.brkSpeed <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.brkWait <= `SBS_RST_BRK_WAIT;
		end else if (wrBrkW) begin
			cfg_reg.brkWait <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_reg.brkEn <= 1'(`SBS_RST_CTRL);
		end else if (wrCtrl) begin
			cfg_reg.brkEn <= pwdata[`SBS_CTRL_BRK_EN];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irqMask_reg <= `SBS_IRQ_BITS'(`SBS_RST_IRQ_MASK);
		end else if (wrIrqM) begin
			irqMask_reg <= pwdata[`SBS_IRQ_BITS-1:0];
		end
	end

	// Read data is loaded in the setup cycle, so it already stands in the access cycle in
	// which the master takes it; pready can then stay high with no wait state.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= 32'h00000000;
		end else if (rdLoad) begin
			prdata_reg <= prdata_next;
		end
	end

	// Alarm comparator and millisecond time base.
	sbs_dev_cmp u_cmp (
		.clk       (clk),
		.nrst      (nrst),
		.deviation (deviation),
		.threshold (cfg_reg.devThr),
		.alarm     (alarm)
	);

	wire servoEdge = servoCmd ^ servoPrev_reg;

	sbs_ms_tick #(
		.CYCLES (MS_CYCLES)
	) u_tick (
		.clk     (clk),
		.nrst    (nrst),
		.restart (servoEdge),
		.tick    (msTick)
	);

	// Elapsed milliseconds since the last servo transition, saturating.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msCnt_reg <= 13'h0000;
		end else if (servoEdge) begin
			msCnt_reg <= 13'h0000;
		end else if (msTick && (msCnt_reg != `SBS_MS_MAX)) begin
			msCnt_reg <= msCnt_reg + 13'h0001;
		end
	end

	// Wait thresholds in milliseconds, recomputed from the live settings.
	wire        onNeg     = cfg_reg.onWait[15];
	wire [15:0] onMagW    = onNeg ? (16'h0000 - cfg_reg.onWait) : cfg_reg.onWait;
	wire [12:0] onMag     = onMagW[12:0];
	wire [19:0] offMsW    = cfg_reg.offWait * 4'(`SBS_UNIT_MS);
	wire [19:0] brkMsW    = cfg_reg.brkWait * 4'(`SBS_UNIT_MS);
	wire        onExcDue  = onNeg || (msCnt_reg >= onMag);
	wire        onBrkDue  = !onNeg || (msCnt_reg >= onMag);
	wire        offExcDue = {7'h00, msCnt_reg} >= offMsW;
	wire        spdNeg    = motorSpeed[15];
	wire [15:0] spdMag    = spdNeg ? (16'h0000 - motorSpeed) : motorSpeed;
	wire        spdLow    = spdMag < cfg_reg.brkSpeed;
	wire        timeOver  = {7'h00, msCnt_reg} > brkMsW;
	wire        offBrkDue = spdLow || timeOver;
	// A stopped motor or a zero off wait acts on the servo-off edge itself, before the
	// restarted millisecond count could be seen.
	wire        offPwKeep = offMsW != 20'h00000;

	always_comb begin
		state_next = state_reg;
		out_next   = out_reg;
		out_next.alarm = alarm;
		if (!cfg_reg.brkEn) begin
			// Without the brake function the motor follows the command directly.
			state_next      = servoCmd ? SBS_ON : SBS_OFF;
			out_next.excite = servoCmd;
			out_next.brake  = 1'b0;
		end else begin
			case (state_reg)
				SBS_OFF: begin
					if (servoCmd) begin
						state_next      = SBS_ON_SEQ;
						out_next.brake  = !onNeg || (onMag == 13'h0000);
						out_next.excite = onNeg || (onMag == 13'h0000);
					end
				end
				SBS_ON_SEQ: begin
					if (!servoCmd) begin
						state_next      = SBS_OFF_SEQ;
						out_next.brake  = out_reg.brake & !spdLow;
						out_next.excite = out_reg.excite & offPwKeep;
					end else begin
						out_next.brake  = out_reg.brake | onBrkDue;
						out_next.excite = out_reg.excite | onExcDue;
						if (out_next.brake && out_next.excite) begin
							state_next = SBS_ON;
						end
					end
				end
				SBS_ON: begin
					if (!servoCmd) begin
						state_next      = SBS_OFF_SEQ;
						out_next.brake  = out_reg.brake & !spdLow;
						out_next.excite = out_reg.excite & offPwKeep;
					end
				end
				SBS_OFF_SEQ: begin
					if (servoCmd) begin
						state_next      = SBS_ON_SEQ;
						out_next.brake  = out_reg.brake | !onNeg;
						out_next.excite = out_reg.excite | onNeg;
					end else begin
						out_next.brake  = out_reg.brake & !offBrkDue;
						out_next.excite = out_reg.excite & !offExcDue;
						if (!out_next.brake && !out_next.excite) begin
							state_next = SBS_OFF;
						end
					end
				end
				default: begin
					state_next = SBS_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg     <= SBS_OFF;
			out_reg       <= '0;
			servoPrev_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			out_reg       <= out_next;
			servoPrev_reg <= servoCmd;
		end
	end

	assign brakeCtrlOut = out_reg.brake;
	assign motorExcite  = out_reg.excite;
	assign devAlarm     = out_reg.alarm;

	// Sticky events; a new event in the clearing read cycle survives the clear.
	// The read clears only the bits that it returned, so an event that lands between the
	// setup and access cycles is kept for the next read.
	logic [`SBS_IRQ_BITS-1:0] irqEvent;
	wire  [`SBS_IRQ_BITS-1:0] irqClr = {`SBS_IRQ_BITS{irqRdClr}} & prdata_reg[`SBS_IRQ_BITS-1:0];
	assign irqEvent[`SBS_IRQ_ALARM]      = alarm && !out_reg.alarm;
	assign irqEvent[`SBS_IRQ_BRAKE_OFF]  = out_reg.brake && !out_next.brake;
	assign irqEvent[`SBS_IRQ_EXCITE_ON]  = !out_reg.excite && out_next.excite;
	assign irqEvent[`SBS_IRQ_EXCITE_OFF] = out_reg.excite && !out_next.excite;
	assign irqStat_next = (irqStat_reg & ~irqClr) | irqEvent;

	genvar gi;
	generate
		for (gi = 0; gi < `SBS_IRQ_BITS; gi++) begin : g_irq
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					irqStat_reg[gi] <= 1'b0;
				end else begin
					irqStat_reg[gi] <= irqStat_next[gi];
				end
			end
		end
	endgenerate

	assign irq = |(irqStat_reg & irqMask_reg);

endmodule : sbs_top

// ### sbs_motor_model.sv
// Behavioural motor and holding brake that stand on the far side of the sequencer.
module sbs_motor_model (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic               motorExcite,
	input  wire logic               brakeCtrlOut,
	input  wire logic signed [15:0] target,
	input  wire logic        [15:0] decel,
	output logic             [15:0] motorSpeed
);
	logic signed [15:0] speedReg;
	wire         [15:0] speedMag = speedReg[15] ? -speedReg : speedReg;
	assign motorSpeed = speedReg;
	// An engaged brake holds the shaft, so the speed falls to zero once the output is low.
	// A decel of zero models a load that coasts forever, to exercise the time limit.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			speedReg <= 16'sh0;
		else if (motorExcite)
			speedReg <= target;
		else if (!brakeCtrlOut || speedMag <= decel)
			speedReg <= 16'sh0;
		else if (speedReg[15])
			speedReg <= speedReg + $signed(decel);
		else
			speedReg <= speedReg - $signed(decel);
	end
endmodule : sbs_motor_model

// ### sbs_top_asserts.sv
// Concurrent checks on the ports of the servo brake sequencer.
module sbs_top_asserts #(
	parameter int MS_CYCLES = 4
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [15:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        servoCmd,
	input wire logic [15:0] motorSpeed,
	input wire logic [31:0] deviation,
	input wire logic        brakeCtrlOut,
	input wire logic        motorExcite,
	input wire logic        devAlarm
);
	logic [31:0] thrReg;
	logic [15:0] onReg, offReg, spdReg, waitReg;
	logic        enReg;
	int          offCntReg;
	wire         wr = psel && penable && pwrite;
	wire  [31:0] devMag = deviation[31] ? -deviation : deviation;
	wire  [15:0] spdMag = motorSpeed[15] ? -motorSpeed : motorSpeed;
	// Shadows of the settings, taken at the same access edge as the device takes a write.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			thrReg <= 32'h02800000;
			onReg <= 16'h0000;
			offReg <= 16'h0000;
			spdReg <= 16'h0064;
			waitReg <= 16'h0032;
			enReg <= 1'b1;
		end else begin
			if (wr && paddr == 16'hcd70) thrReg <= pwdata;
			if (wr && paddr == 16'hcd74) onReg <= pwdata[15:0];
			if (wr && paddr == 16'hcd78) offReg <= pwdata[15:0];
			if (wr && paddr == 16'hcd7c) spdReg <= pwdata[15:0];
			if (wr && paddr == 16'hcd80) waitReg <= pwdata[15:0];
			if (wr && paddr == 16'hcdc0) enReg <= pwdata[0];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) offCntReg <= 0;
		else if (servoCmd) offCntReg <= 0;
		else if (offCntReg < 100000) offCntReg <= offCntReg + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_ALARM_SET: assert property ((devMag > thrReg)[*3] |-> devAlarm)
		else $error("alarm missing above threshold");
	AST_ALARM_CLR: assert property ((devMag <= thrReg)[*3] |-> !devAlarm)
		else $error("alarm raised at or below threshold");
	AST_ON_POS: assert property ($rose(servoCmd) && enReg && !onReg[15] && onReg != 16'h0
		&& !brakeCtrlOut && !motorExcite |=> brakeCtrlOut && !motorExcite)
		else $error("positive wait did not lead with the brake output");
	AST_ON_NEG: assert property ($rose(servoCmd) && enReg && onReg[15]
		&& !brakeCtrlOut && !motorExcite |=> motorExcite && !brakeCtrlOut)
		else $error("negative wait did not lead with excitation");
	AST_OFF_STOP: assert property ($fell(servoCmd) && enReg && brakeCtrlOut
		&& spdMag < spdReg |=> !brakeCtrlOut)
		else $error("brake output held after stopped servo off");
	AST_OFF_PWR: assert property ($fell(servoCmd) && enReg && motorExcite
		&& offReg == 16'h0 |-> ##[1:2] !motorExcite)
		else $error("power kept with zero off wait");
	AST_SPD_LOW: assert property ((!servoCmd && enReg && spdMag < spdReg)[*3]
		|-> !brakeCtrlOut)
		else $error("brake output high below speed threshold");
	AST_BRK_TIME: assert property (!servoCmd && enReg && brakeCtrlOut
		|-> offCntReg <= (int'(waitReg) * 10 + 1) * MS_CYCLES + 6)
		else $error("brake output held past wait time");
	AST_DISABLED: assert property ((!enReg)[*3]
		|-> !brakeCtrlOut && motorExcite == $past(servoCmd))
		else $error("brake timing active while function is off");
	cover property ($rose(devAlarm));
	cover property ($fell(brakeCtrlOut) && !servoCmd);
	cover property ($rose(motorExcite) && brakeCtrlOut);
endmodule : sbs_top_asserts
bind sbs_top sbs_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk, .nrst, .paddr, .psel,
	.penable, .pwrite, .pwdata, .servoCmd, .motorSpeed, .deviation, .brakeCtrlOut,
	.motorExcite, .devAlarm);

// ### servo_brake_sequencer_tb.sv
// Self-checking bench for the servo brake sequencer driving a motor model.
module servo_brake_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, servoCmd = 0;
	logic        [15:0] paddr = 16'h0, decel = 16'h0, motorSpeed;
	logic signed [15:0] target = 16'sh0;
	logic        [31:0] pwdata = 32'h0, deviation = 32'h0, prdata, q;
	logic               pready, pslverr, brakeCtrlOut, motorExcite, devAlarm, irq, e;
	int                 n_fail = 0, checked = 0, n;
	always #25 clk = ~clk;
	sbs_top #(.MS_CYCLES(4)) dut (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .servoCmd, .motorSpeed, .deviation, .brakeCtrlOut,
		.motorExcite, .devAlarm, .irq);
	sbs_motor_model motor (.clk, .nrst, .motorExcite, .brakeCtrlOut, .target, .decel,
		.motorSpeed);
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
		checked++;
		if (got !== x) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, x, got);
		end
	endtask : chk
	task automatic rng(input string nm, input int lo, input int hi);
		checked++;
		if (n < lo || n > hi) begin
			n_fail++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask : rng
	// Read data stands in the access cycle and is taken at the edge that samples pready.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		e = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_fail++;
			print_verdict();
		end
	endtask : apb
	task automatic srv(input logic v);
		@(posedge clk);
		servoCmd <= v;
		n = 0;
	endtask : srv
	// Counts cycles since the last servo change until the chosen output reaches v.
	task automatic wt(input logic excite, input logic v);
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((excite ? motorExcite : brakeCtrlOut) !== v && n < 3000);
		if (n >= 3000) begin
			n_fail++;
			print_verdict();
		end
	endtask : wt
	initial begin
		static logic [15:0] ad [7] = '{16'hcd70, 16'hcd74, 16'hcd78, 16'hcd7c, 16'hcd80, 16'hcdc0,
			16'hcdcc};
		static logic [31:0] rv [7] = '{32'h02800000, 32'h0, 32'h0, 32'h64, 32'h32, 32'h1, 32'h0};
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk("reset value", rv[i], q);
		end
		apb(1'b0, 16'h0100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		apb(1'b1, 16'hcd70, 32'h05000000);
		apb(1'b0, 16'hcd70, 32'h0);
		chk("max threshold", 32'h05000000, q);
		$display("test registers done");
		apb(1'b1, 16'hcd70, 32'd1000);
		deviation <= 32'd1001;
		repeat (4) @(posedge clk);
		chk("alarm above", 32'h1, {31'h0, devAlarm});
		chk("irq masked", 32'h0, {31'h0, irq});
		deviation <= -32'd1001;
		repeat (4) @(posedge clk);
		chk("alarm negative", 32'h1, {31'h0, devAlarm});
		deviation <= 32'd1000;
		repeat (4) @(posedge clk);
		chk("alarm at threshold", 32'h0, {31'h0, devAlarm});
		apb(1'b1, 16'hcdcc, 32'h1);
		@(negedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b0, 16'hcdc8, 32'h0);
		chk("irq status", 32'h1, q);
		@(negedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test alarm done");
		apb(1'b1, 16'hcd74, 32'd2);
		apb(1'b1, 16'hcd80, 32'd10);
		target <= 16'sd500;
		srv(1'b1);
		wt(1'b0, 1'b1);
		rng("brake lead", 1, 1);
		chk("excite early", 32'h0, {31'h0, motorExcite});
		wt(1'b1, 1'b1);
		rng("excite delay", 8, 11);
		apb(1'b0, 16'hcdc4, 32'h0);
		chk("status on", 32'h23, q);
		srv(1'b0);
		wt(1'b1, 1'b0);
		rng("power off", 1, 2);
		wt(1'b0, 1'b0);
		rng("brake time", 404, 410);
		$display("test positive wait done");
		apb(1'b1, 16'hcd74, 32'h0000fffd);
		apb(1'b1, 16'hcd78, 32'd2);
		target <= 16'sd0;
		srv(1'b1);
		wt(1'b1, 1'b1);
		rng("excite lead", 1, 1);
		chk("brake early", 32'h0, {31'h0, brakeCtrlOut});
		wt(1'b0, 1'b1);
		rng("brake delay", 12, 15);
		srv(1'b0);
		wt(1'b0, 1'b0);
		rng("stopped brake", 1, 1);
		wt(1'b1, 1'b0);
		rng("power delay", 80, 84);
		$display("test negative wait done");
		apb(1'b1, 16'hcd78, 32'd0);
		target <= -16'sd500;
		decel <= 16'd10;
		srv(1'b1);
		wt(1'b0, 1'b1);
		srv(1'b0);
		wt(1'b0, 1'b0);
		rng("speed brake", 41, 48);
		$display("test speed threshold done");
		apb(1'b1, 16'hcdc0, 32'h0);
		srv(1'b1);
		wt(1'b1, 1'b1);
		rng("plain excite", 1, 1);
		chk("brake unused", 32'h0, {31'h0, brakeCtrlOut});
		srv(1'b0);
		wt(1'b1, 1'b0);
		rng("plain release", 1, 1);
		apb(1'b0, 16'hcdc8, 32'h0);
		chk("irq events", 32'he, q);
		$display("test function off done");
		print_verdict();
	end
endmodule : servo_brake_sequencer_tb
